/* File: logic/cfg_port_pkg.sv */
// constants and types for the configuration index/data port block
// ----------------------------------------------------------------
// Summary of operation
// - index on port 22h, data on 23h
// - unselected or repeated data access goes external
// - index port reads always go external
// - on-chip hits complete without external cycle
// - C0-CFh and FC-FFh always reachable
// - D0-FBh reachable only when map enable 1h
// - map enable 1h: index writes never go external
// - map enable 0h: other indexes go external
// - reset clears every configuration bit
// - seven control, eight region, eight region-control
// ----------------------------------------------------------------
package cfg_port_pkg;
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA = 16'h0023;
  // index windows
  localparam logic [7:0] IDX_BASE = 8'hC0;
  localparam logic [7:0] IDX_LOW_OPEN_LAST = 8'hCF;
  localparam logic [7:0] IDX_HIGH_OPEN_FIRST = 8'hFC;
  localparam logic [7:0] IDX_CTRL3 = 8'hC3;
  localparam logic [7:0] IDX_ID0 = 8'hFE;
  localparam logic [7:0] IDX_ID1 = 8'hFF;
  // map enable field sits in control register three bits 7..4
  localparam int MAP_FIELD_LSB = 4;
  localparam logic [3:0] MAP_OPEN = 4'h1;
  // stored bytes C0h..FFh, implemented: C0-E3 (ccr0-3, arr0-7, rcr0-7), E8-EA (ccr4-6)
  localparam int STORE_DEPTH = 64;
  localparam logic [63:0] IMPL_MASK = 64'h0000_070F_FFFF_FFFF;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // identification bytes, values arbitrary
  localparam logic [7:0] ID0_VALUE = 8'h5A;
  localparam logic [7:0] ID1_VALUE = 8'h01;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXT = 1'b1
  } phase_t;
endpackage

/* File: logic/cfg_reg_store.sv */
// byte storage for the configuration register set
module cfg_reg_store
  import cfg_port_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic wr_en, // write one byte this cycle
  input wire logic [7:0] idx, // register index
  input wire logic [7:0] wr_data, // byte to write
  output logic [7:0] rd_data, // byte at idx, combinational
  output logic [3:0] map_enable_field // map enable field of control register three
);
  typedef struct packed {
    logic [STORE_DEPTH-1:0][7:0] bytes;
  } store_t;

  store_t cur;
  store_t next_cur;
  logic [5:0] slot;
  logic in_store;

  assign slot = idx[5:0];
  assign in_store = (idx >= IDX_BASE);

  // write decode: only implemented slots take data
  always_comb begin
    next_cur = cur;
    for (int i = 0; i < STORE_DEPTH; i++) begin
      if (wr_en && in_store && (slot == 6'(i)) && IMPL_MASK[i]) begin
        next_cur.bytes[i] = wr_data;
      end
    end
  end

  // all bytes clear on reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // read: id bytes are constants, holes read zero
  always_comb begin
    rd_data = RESET_BYTE;
    if (idx == IDX_ID0) begin
      rd_data = ID0_VALUE;
    end else if (idx == IDX_ID1) begin
      rd_data = ID1_VALUE;
    end else if (in_store && IMPL_MASK[slot]) begin
      rd_data = cur.bytes[slot];
    end
  end

  assign map_enable_field = cur.bytes[6'(IDX_CTRL3 - IDX_BASE)][MAP_FIELD_LSB +: 4];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  id_fixed_a: assert property (1'b1 |-> cur.bytes[63] == RESET_BYTE)
    else $error("id slot storage changed");
  write_lands_a: assert property (
    ce && wr_en && in_store && IMPL_MASK[slot] |=> cur.bytes[$past(slot)] == $past(wr_data))
    else $error("write did not land");
endmodule

/* File: logic/config_index_data_port.sv */
// index/data port decode between the core I/O path and the external I/O bus
module config_index_data_port
  import cfg_port_pkg::*;
(
  input wire logic ref_clk, // core clock, 25 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic core_req, // core I/O request valid
  output logic core_ready, // request can be taken
  input wire logic core_wr, // 1 write, 0 read
  input wire logic [15:0] core_port, // I/O port number
  input wire logic [7:0] core_wdata, // write data
  output logic core_ack, // one-cycle completion pulse
  output logic [7:0] core_rdata, // read data, valid with core_ack
  output logic ext_req, // external I/O cycle request, held to ext_ack
  output logic ext_wr, // external cycle direction
  output logic [15:0] ext_port, // external cycle port
  output logic [7:0] ext_wdata, // external cycle write data
  input wire logic ext_ack, // external cycle done
  input wire logic [7:0] ext_rdata // external read data, valid with ext_ack
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [7:0] idx;
    logic idx_valid;
    logic core_ack;
    logic [7:0] core_rdata;
    logic ext_req;
    logic ext_wr;
    logic [15:0] ext_port;
    logic [7:0] ext_wdata;
  } port_state_t;

  port_state_t cur;
  port_state_t next_cur;

  logic take;
  logic [7:0] look_idx;
  logic [7:0] store_rd;
  logic [3:0] map_enable_field;
  logic store_wr;
  logic is_index;
  logic is_data;
  logic new_idx_ok;
  logic cur_idx_ok;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // accessibility: low and high windows always, everything when map is open
  function automatic logic idx_open(input logic [7:0] i, input logic [3:0] map);
    logic always_on;
    always_on = (i >= IDX_BASE && i <= IDX_LOW_OPEN_LAST) || (i >= IDX_HIGH_OPEN_FIRST);
    idx_open = always_on || (map == MAP_OPEN);
  endfunction

  assign core_ready = (cur.phase == ST_IDLE);
  assign take = ce && core_req && core_ready;
  assign is_index = (core_port == PORT_INDEX);
  assign is_data = (core_port == PORT_DATA);
  assign new_idx_ok = idx_open(core_wdata, map_enable_field);
  assign cur_idx_ok = cur.idx_valid && idx_open(cur.idx, map_enable_field);
  assign look_idx = cur.idx;
  // internal data write only on a fresh, open selection
  assign store_wr = take && is_data && core_wr && cur_idx_ok;

  cfg_reg_store u_store (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_en(store_wr),
    .idx(look_idx),
    .wr_data(core_wdata),
    .rd_data(store_rd),
    .map_enable_field(map_enable_field)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one access at a time: internal hits answer next cycle, others go out
  always_comb begin
    next_cur = cur;
    next_cur.core_ack = 1'b0;
    case (cur.phase)
      ST_IDLE: begin
        if (take) begin
          // any access consumes the current selection
          next_cur.idx_valid = 1'b0;
          if (is_index && core_wr && new_idx_ok) begin
            next_cur.idx = core_wdata;
            next_cur.idx_valid = 1'b1;
            next_cur.core_ack = 1'b1;
          end else if (is_data && cur_idx_ok) begin
            next_cur.core_ack = 1'b1;
            next_cur.core_rdata = core_wr ? cur.core_rdata : store_rd;
          end else begin
            // index reads, unselected data, closed indexes, other ports
            next_cur.phase = ST_EXT;
            next_cur.ext_req = 1'b1;
            next_cur.ext_wr = core_wr;
            next_cur.ext_port = core_port;
            next_cur.ext_wdata = core_wdata;
          end
        end
      end
      ST_EXT: begin
        if (ext_ack) begin
          next_cur.phase = ST_IDLE;
          next_cur.ext_req = 1'b0;
          next_cur.core_ack = 1'b1;
          if (!cur.ext_wr) begin
            next_cur.core_rdata = ext_rdata;
          end
        end
      end
      default: begin
        next_cur.phase = ST_IDLE;
        next_cur.ext_req = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // state register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign core_ack = cur.core_ack;
  assign core_rdata = cur.core_rdata;
  assign ext_req = cur.ext_req;
  assign ext_wr = cur.ext_wr;
  assign ext_port = cur.ext_port;
  assign ext_wdata = cur.ext_wdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence idx_write_s;
    take && is_index && core_wr;
  endsequence

  sequence data_take_s;
    take && is_data;
  endsequence

  sequence sel_then_data_s;
    idx_write_s ##1 data_take_s;
  endsequence

  idx_read_ext_a: assert property (take && is_index && !core_wr |=> ext_req && !core_ack)
    else $error("index read not forwarded");

  hit_internal_a: assert property (data_take_s and (cur_idx_ok) |=> !ext_req && core_ack)
    else $error("hit made external cycle");

  repeat_data_ext_a: assert property (data_take_s and (!cur.idx_valid) |=> ext_req)
    else $error("unselected data not forwarded");

  select_data_pair_a: assert property (
    (idx_write_s and (new_idx_ok)) ##1 data_take_s |=> core_ack && !ext_req)
    else $error("select then data not internal");

  open_window_a: assert property (
    idx_write_s and (core_wdata >= IDX_BASE && core_wdata <= IDX_LOW_OPEN_LAST)
    |=> cur.idx_valid)
    else $error("low window selection refused");

  map_gate_a: assert property (
    idx_write_s and (core_wdata >= 8'hD0 && core_wdata <= 8'hFB)
    |=> cur.idx_valid == ($past(map_enable_field) == MAP_OPEN))
    else $error("map gate wrong");

  map_open_a: assert property (
    idx_write_s and (map_enable_field == MAP_OPEN) |=> !ext_req && cur.idx_valid)
    else $error("external cycle with map open");

  map_closed_a: assert property (
    idx_write_s and (map_enable_field == 4'h0) and (core_wdata > IDX_LOW_OPEN_LAST)
    and (core_wdata < IDX_HIGH_OPEN_FIRST) |=> ext_req && !cur.idx_valid)
    else $error("closed index not forwarded");

  flag_once_a: assert property (data_take_s |=> !cur.idx_valid ##1 !cur.idx_valid || $past(take))
    else $error("selection served twice");

  fwd_hold_a: assert property (ext_req && !(ce && ext_ack) |=> ext_req && $stable(ext_port)
    && $stable(ext_wdata) && $stable(ext_wr))
    else $error("forwarded access changed");

  fwd_copy_a: assert property (take && !is_index && !is_data |=> ext_req
    && ext_port == $past(core_port) && ext_wr == $past(core_wr))
    else $error("forwarded fields differ");

  ext_return_a: assert property (ce && ext_req && ext_ack && !ext_wr
    |=> core_ack && core_rdata == $past(ext_rdata) && !ext_req)
    else $error("bus read data not returned");

  second_data_ext_a: assert property (sel_then_data_s ##1 data_take_s |=> ext_req && !core_ack)
    else $error("second data access not forwarded");
endmodule

/* File: verification/ext_bus_model.sv */
// external i/o bus responder facing the configuration port block
module ext_bus_model (
  input wire logic ref_clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic ext_req, // cycle request
  input wire logic [15:0] ext_port, // cycle port
  input wire logic [1:0] dly, // wait edges before ack
  output logic ext_ack, // cycle done
  output logic [7:0] ext_rdata // read data, junk outside ack
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial begin
    ext_ack = 1'b0;
    ext_rdata = 8'hA5;
  end
  // answer a held request after dly edges; data changes every idle cycle
  always @(posedge ref_clk) begin
    #1;
    if (rst_b && ext_req && !ext_ack && cnt >= dly) begin
      ext_ack = 1'b1;
      ext_rdata = ext_port[7:0] ^ 8'h3C;
      cnt = 0;
    end else begin
      ext_ack = 1'b0;
      ext_rdata = ~ext_rdata;
      cnt = (rst_b && ext_req) ? cnt + 1 : 0;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the configuration index/data port block
module tb_top
  import cfg_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic ext;
    logic wr;
    logic [15:0] port;
    logic [7:0] wd;
    logic [7:0] rd;
  } note_t;
  logic ref_clk = 1'b0;
  logic rst_b, ce, core_req, core_ready, core_wr, core_ack, ext_req, ext_wr, ext_ack, sel, seen;
  logic [15:0] core_port, ext_port;
  logic [7:0] core_wdata, core_rdata, ext_wdata, ext_rdata, sidx;
  logic [7:0] mem [256];
  logic [1:0] dly;
  logic [24:0] cap;
  note_t notes[$];
  note_t cur;
  int err_total = 0;
  int n_compared = 0;

  always #20 ref_clk = ~ref_clk;

  config_index_data_port uut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .core_req(core_req),
    .core_ready(core_ready), .core_wr(core_wr), .core_port(core_port), .core_wdata(core_wdata),
    .core_ack(core_ack), .core_rdata(core_rdata), .ext_req(ext_req), .ext_wr(ext_wr),
    .ext_port(ext_port), .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
  ext_bus_model pm (.ref_clk(ref_clk), .rst_b(rst_b), .ext_req(ext_req), .ext_port(ext_port),
    .dly(dly), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic open_idx(input logic [7:0] i);
    return (i >= IDX_BASE && i <= IDX_LOW_OPEN_LAST) || i >= IDX_HIGH_OPEN_FIRST
      || mem[IDX_CTRL3][7:4] == MAP_OPEN;
  endfunction
  function automatic logic impl(input logic [7:0] i);
    return i >= IDX_BASE && IMPL_MASK[i[5:0]];
  endfunction
  function automatic logic [7:0] rd_byte(input logic [7:0] i);
    return i == IDX_ID0 ? ID0_VALUE : i == IDX_ID1 ? ID1_VALUE : impl(i) ? mem[i] : 8'h00;
  endfunction
  // note the expected outcome, then hold the request until taken
  task automatic acc(input logic wr, input logic [15:0] port, input logic [7:0] d);
    note_t n;
    logic r;
    n = '{ext: 1'b1, wr: wr, port: port, wd: d, rd: port[7:0] ^ 8'h3C};
    if (port == PORT_INDEX && wr && open_idx(d)) n.ext = 1'b0;
    if (port == PORT_DATA && sel && open_idx(sidx)) begin
      n.ext = 1'b0;
      n.rd = rd_byte(sidx);
      if (wr && impl(sidx)) mem[sidx] = d;
    end
    sel = port == PORT_INDEX && wr && open_idx(d);
    sidx = d;
    notes.push_back(n);
    dly = 2'($urandom_range(0, 3));
    core_req = 1'b1;
    core_wr = wr;
    core_port = port;
    core_wdata = d;
    forever begin
      r = core_ready;
      @(posedge ref_clk);
      if (r) break;
      #1;
    end
    #1;
  endtask
  task automatic settle();
    core_req = 1'b0;
    @(posedge ref_clk);
    #1;
    while (notes.size() != 0) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    sel = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (20) @(posedge ref_clk);
    chk({core_ready, core_ack, ext_req}, 3'b100);
    #1 rst_b = 1'b1;
  endtask

  // ----------------------------------------
  // watcher: pair each completion with the oldest note
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) seen = 1'b0;
    else begin
      if (ext_req && ext_ack) begin
        seen = 1'b1;
        cap = {ext_wr, ext_port, ext_wdata};
      end
      if (core_ack) begin
        chk(notes.size() != 0, 1'b1);
        cur = notes.pop_front();
        chk(seen, cur.ext);
        if (cur.ext) chk(cap[24:8], {cur.wr, cur.port});
        if (cur.ext && cur.wr) chk(cap[7:0], cur.wd);
        if (!cur.wr) chk(core_rdata, cur.rd);
        seen = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    void'($urandom(32'h32650772));
    ce = 1'b1;
    core_req = 1'b0;
    core_wr = 1'b0;
    core_port = 16'h0000;
    core_wdata = 8'h00;
    dly = 2'h0;
    do_reset();
    for (int i = 192; i < 256; i++) begin
      acc(1'b1, PORT_INDEX, 8'(i));
      acc(1'b0, PORT_DATA, 8'h00);
    end
    for (int i = 192; i < 208; i++) begin
      acc(1'b1, PORT_INDEX, 8'(i));
      acc(1'b1, PORT_DATA, i == 195 ? 8'h00 : 8'($urandom));
      acc(1'b1, PORT_INDEX, 8'(i));
      acc(1'b0, PORT_DATA, 8'h00);
    end
    acc(1'b1, PORT_INDEX, 8'hC1);
    acc(1'b0, PORT_DATA, 8'h00);
    acc(1'b0, PORT_DATA, 8'h00);
    acc(1'b1, PORT_DATA, 8'($urandom));
    acc(1'b0, PORT_INDEX, 8'h00);
    acc(1'b1, 16'h0080, 8'($urandom));
    acc(1'b1, PORT_INDEX, 8'h10);
    acc(1'b1, PORT_DATA, 8'h05);
    acc(1'b1, PORT_INDEX, IDX_CTRL3);
    acc(1'b1, PORT_DATA, 8'h10);
    for (int i = 0; i < 256; i++) begin
      if (i != 195) begin
        acc(1'b1, PORT_INDEX, 8'(i));
        acc(1'b1, PORT_DATA, 8'($urandom));
        acc(1'b1, PORT_INDEX, 8'(i));
        acc(1'b0, PORT_DATA, 8'h00);
      end
    end
    acc(1'b0, PORT_INDEX, 8'h00);
    acc(1'b1, PORT_INDEX, IDX_CTRL3);
    acc(1'b1, PORT_DATA, 8'h00);
    acc(1'b1, PORT_INDEX, 8'hD5);
    acc(1'b0, PORT_DATA, 8'h00);
    settle();
    do_reset();
    acc(1'b1, PORT_INDEX, 8'hC0);
    acc(1'b0, PORT_DATA, 8'h00);
    settle();
    wrap_up();
  end
  initial begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule
